// file: ll_dram_params.svh
// Offsets, field positions, reset values and timing counts of the DRAM core.
`ifndef LL_DRAM_PARAMS_SVH
`define LL_DRAM_PARAMS_SVH
`define LL_ADDR_W        20
`define LL_BANK_W        3
`define LL_CFG_LSB       0
`define LL_BURST_LSB     3
`define LL_CFG_SEL_1     3'h0
`define LL_CFG_SEL_2     3'h1
`define LL_CFG_SEL_3     3'h2
`define LL_LAT_1         4'h4
`define LL_LAT_2         4'h6
`define LL_LAT_3         4'h8
`define LL_RL_MAX        8
`define LL_BURST_SEL_2   2'h0
`define LL_BURST_SEL_4   2'h1
`define LL_BURST_SEL_8   2'h2
`define LL_BURST_2       4'h2
`define LL_BURST_4       4'h4
`define LL_BURST_8       4'h8
`define LL_MODE_RUN_RST  2'h2
`define LL_CFG_RESET     3'h0
`define LL_BURST_RESET   2'h0
`endif

// file: ll_dram_pkg.sv
// Types shared by the DRAM read, refresh and initialization logic.
`include "ll_dram_params.svh"
package ll_dram_pkg;
	typedef struct packed {
		logic                  ck;
		logic                  diffOk;
		logic                  csN;
		logic                  weN;
		logic                  refN;
		logic [`LL_BANK_W-1:0] bank;
		logic [`LL_ADDR_W-1:0] addr;
	} pins_t;

	typedef struct packed {
		logic                  valid;
		logic [`LL_BANK_W-1:0] bank;
		logic [`LL_ADDR_W-1:0] addr;
	} entry_t;

	typedef enum logic [2:0] {
		CMD_IDLE,
		CMD_READ,
		CMD_WRITE,
		CMD_REFRESH,
		CMD_MODE
	} cmd_kind_t;
endpackage : ll_dram_pkg

// file: ll_dram_core.sv
// Read burst, per-bank refresh and mode-load logic of the DRAM device.
`timescale 1ns/1ps
`default_nettype none
`include "ll_dram_params.svh"
module ll_dram_core #(
	parameter int DATA_W = 18,
	parameter int ROW_W  = 13,
	parameter int BANKS  = 8
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire ll_dram_pkg::pins_t      pins,
	input  wire logic [DATA_W-1:0]       coreData,
	output var  logic [DATA_W-1:0]       readData,
	output var  logic                    readDataOe,
	output var  logic [1:0]              readDataClockPair,
	output var  logic                    readValidStrobe,
	output var  logic [`LL_ADDR_W-1:0]   coreAddr,
	output var  logic [`LL_BANK_W-1:0]   coreBank,
	output var  logic                    refreshPulse,
	output var  logic [`LL_BANK_W-1:0]   refreshBank,
	output var  logic [ROW_W-1:0]        refreshRow,
	output var  logic                    initDone
);
	import ll_dram_pkg::*;

	localparam int MAXRL = `LL_RL_MAX;

	generate
		if (DATA_W < 2 || DATA_W % 2 != 0 || BANKS != 2 ** `LL_BANK_W ||
		    ROW_W < 1) begin : g_bad
			$error("ll_dram_core: unsupported parameter values");
		end
	endgenerate

	typedef struct packed {
		pins_t                         sA;
		pins_t                         sB;
		logic                          ckPrev;
		entry_t [MAXRL-1:0]            pipe;
		logic [2:0]                    cfg;
		logic [1:0]                    bsel;
		logic [1:0]                    modeRun;
		logic                          modeSeen;
		logic [3:0]                    beatsLeft;
		logic                          stuck;
		logic [`LL_ADDR_W-1:0]         coreAddr;
		logic [`LL_BANK_W-1:0]         coreBank;
		logic [DATA_W-1:0]             q;
		logic                          qOe;
		logic [1:0]                    qk;
		logic                          strobe;
		logic [BANKS-1:0][ROW_W-1:0]   rowCnt;
		logic [BANKS-1:0]              refreshed;
		logic                          initDone;
		logic                          refreshPulse;
		logic [`LL_BANK_W-1:0]         refreshBank;
		logic [ROW_W-1:0]              refreshRow;
	} state_t;

	state_t    s;
	state_t    next_s;
	logic      rise;
	logic      fall;
	cmd_kind_t kind;
	logic [3:0] rl;
	logic [3:0] bl;
	logic [2:0] rlIdx;
	logic      modeReset;
	entry_t    newEntry;

	assign rise = s.sB.ck & ~s.ckPrev;
	assign fall = ~s.sB.ck & s.ckPrev;
	assign rlIdx = 3'(rl - 4'h1);
	assign modeReset = rise && kind == CMD_MODE &&
	                   s.modeRun >= `LL_MODE_RUN_RST;

	always_comb begin
		kind = CMD_IDLE;
		if (!s.sB.csN) begin
			if (s.sB.weN && s.sB.refN) begin
				kind = CMD_READ;
			end else if (!s.sB.weN && s.sB.refN) begin
				kind = CMD_WRITE;
			end else if (s.sB.weN && !s.sB.refN) begin
				kind = CMD_REFRESH;
			end else begin
				kind = CMD_MODE;
			end
		end
	end

	always_comb begin
		case (s.cfg)
			`LL_CFG_SEL_2: rl = `LL_LAT_2;
			`LL_CFG_SEL_3: rl = `LL_LAT_3;
			default:       rl = `LL_LAT_1;
		endcase
		case (s.bsel)
			`LL_BURST_SEL_4: bl = `LL_BURST_4;
			`LL_BURST_SEL_8: bl = `LL_BURST_8;
			default:         bl = `LL_BURST_2;
		endcase
	end

	always_comb begin
		next_s = s;
		newEntry = '0;
		next_s.sA = pins;
		next_s.sB = s.sA;
		next_s.ckPrev = s.sB.ck;
		// Both read clocks follow the input clock, so they never stop.
		next_s.qk = {2{s.sB.ck}};
		next_s.refreshPulse = 1'b0;
		if (rise) begin
			newEntry.valid = kind == CMD_READ;
			newEntry.bank = s.sB.bank;
			newEntry.addr = s.sB.addr;
			next_s.pipe = {s.pipe[MAXRL-2:0], newEntry};
			// Writes take no read resource, so they pass straight on.
			if (kind == CMD_READ) begin
				next_s.stuck = 1'b0;
			end
			if (kind == CMD_REFRESH) begin
				next_s.rowCnt[s.sB.bank] = ROW_W'(s.rowCnt[s.sB.bank] + 1'b1);
				next_s.refreshPulse = 1'b1;
				next_s.refreshBank = s.sB.bank;
				next_s.refreshRow = s.rowCnt[s.sB.bank];
				next_s.refreshed[s.sB.bank] = 1'b1;
				if (&next_s.refreshed && s.modeSeen) begin
					next_s.initDone = 1'b1;
				end
			end
			if (kind == CMD_MODE) begin
				next_s.cfg = s.sB.addr[`LL_CFG_LSB +: 3];
				next_s.bsel = s.sB.addr[`LL_BURST_LSB +: 2];
				next_s.modeSeen = 1'b1;
				if (s.modeRun != 2'h3) begin
					next_s.modeRun = 2'(s.modeRun + 1'b1);
				end
				if (modeReset) begin
					next_s.rowCnt = '0;
					next_s.refreshed = '0;
					next_s.initDone = 1'b0;
					next_s.pipe = '0;
					next_s.beatsLeft = '0;
					next_s.stuck = 1'b0;
					next_s.strobe = 1'b0;
				end
			end else begin
				next_s.modeRun = 2'h0;
			end
		end
		if ((rise || fall) && !modeReset) begin
			if (s.beatsLeft != 4'h0) begin
				// The core word was fetched one edge early; drive it now.
				next_s.q = coreData;
				next_s.qOe = 1'b1;
				next_s.beatsLeft = 4'(s.beatsLeft - 1'b1);
				next_s.coreAddr = `LL_ADDR_W'(s.coreAddr + 1'b1);
				if (s.beatsLeft == 4'h1) begin
					next_s.strobe = 1'b0;
				end
			end else begin
				next_s.q = '0;
				next_s.qOe = 1'b0;
			end
			// A read due at the next rise loads here, on the same edge as
			// the last word of the burst before it, so no gap opens.
			if (fall && s.pipe[rlIdx].valid && s.beatsLeft <= 4'h1) begin
				next_s.strobe = 1'b1;
				next_s.coreAddr = s.pipe[rlIdx].addr;
				next_s.coreBank = s.pipe[rlIdx].bank;
				next_s.beatsLeft = bl;
			end
		end
		// A bad input clock in a burst latches the strobe high.
		if (!s.sB.diffOk && s.beatsLeft != 4'h0) begin
			next_s.stuck = 1'b1;
		end
		if (next_s.stuck) begin
			next_s.strobe = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign readData = s.q;
	assign readDataOe = s.qOe;
	assign readDataClockPair = s.qk;
	assign readValidStrobe = s.strobe;
	assign coreAddr = s.coreAddr;
	assign coreBank = s.coreBank;
	assign refreshPulse = s.refreshPulse;
	assign refreshBank = s.refreshBank;
	assign refreshRow = s.refreshRow;
	assign initDone = s.initDone;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence sStrobeUp;
		$rose(readValidStrobe) && !s.stuck;
	endsequence
	sequence sDataUp;
		##[1:8] $rose(readDataOe);
	endsequence

	a_strobe_lead: assert property (sStrobeUp |-> sDataUp)
		else $error("strobe rose without data following");
	a_strobe_last: assert property ($fell(readValidStrobe) |-> readDataOe)
		else $error("strobe fell outside a data word");
	a_data_float: assert property (
		$fell(readValidStrobe) |-> ##[1:8] !readDataOe)
		else $error("data kept driven after burst end");
	a_stuck_hold: assert property (s.stuck |-> readValidStrobe)
		else $error("strobe dropped while clock fault latched");
	a_clock_runs: assert property (##1 1'b1 |-> ##[1:8]
		$changed(readDataClockPair[0]))
		else $error("read data clock stopped");
	a_pair_match: assert property (
		readDataClockPair[0] == readDataClockPair[1])
		else $error("read data clocks out of step");
	a_read_latency: assert property (
		fall && !modeReset && s.pipe[rlIdx].valid && s.beatsLeft <= 4'h1
		|=> s.beatsLeft == $past(bl) && coreAddr == $past(s.pipe[rlIdx].addr))
		else $error("burst not loaded at read latency");
	a_refresh_step: assert property (
		rise && kind == CMD_REFRESH && !modeReset |=> refreshPulse &&
		refreshBank == $past(s.sB.bank) &&
		refreshRow == $past(s.rowCnt[s.sB.bank]))
		else $error("refresh did not report bank row");
	a_mode_reset: assert property (modeReset |=> !initDone &&
		s.rowCnt == '0 && !readValidStrobe)
		else $error("consecutive mode loads did not reset");
	// A word with the strobe still high means another word is due, either
	// from this burst or from the next one loaded at its last edge.
	a_stream_gap: assert property (
		readDataOe && readValidStrobe && !s.stuck
		|-> ##4 readDataOe)
		else $error("gap between back-to-back bursts");
endmodule : ll_dram_core
`default_nettype wire

// file: ll_ctrl_model.sv
// Controller model that drives the command pins of the DRAM device.
`timescale 1ns/1ps
`default_nettype none
module ll_ctrl_model (
	input  wire logic               clk,
	output var  ll_dram_pkg::pins_t pins,
	output var  int                 ckRises
);
	import ll_dram_pkg::*;
	logic [1:0]  ph = 2'h0;
	logic        ck = 1'b0;
	logic        diffOk = 1'b1;
	logic        csN = 1'b1;
	logic        weN = 1'b1;
	logic        refN = 1'b1;
	logic [2:0]  bank = 3'h0;
	logic [19:0] addr = 20'h00000;
	logic [25:0] q[$];
	int          taken = 0;
	initial ckRises = 0;
	always_comb pins = '{ck, diffOk, csN, weN, refN, bank, addr};
	// Pins change on the clock fall, so they stand half a period each side.
	always @(posedge clk) begin
		ph <= ph + 2'h1;
		if (ph == 2'h3) begin
			ck <= ~ck;
			if (!ck)
				ckRises <= ckRises + 1;
			if (ck && q.size() > 0) begin
				{csN, weN, refN, bank, addr} <= q.pop_front();
				taken <= taken + 1;
			end else if (ck) begin
				{csN, weN, refN} <= 3'b111;
				addr <= ~addr;
			end
		end
	end
	// Returns at the clock edge on which the command's rise is launched.
	task automatic cmd(input logic [2:0] k, b, input logic [19:0] a);
		int n;
		n = taken;
		q.push_back({k, b, a});
		while (taken == n)
			@(posedge clk);
		repeat (3) @(posedge clk);
	endtask : cmd
endmodule : ll_ctrl_model
`default_nettype wire

// file: ll_dram_core_tb.sv
// Self-checking bench for the DRAM read, refresh and init logic.
`timescale 1ns/1ps
`default_nettype none
module ll_dram_core_tb;
	import ll_dram_pkg::*;
	localparam logic [2:0] RD = 3'b011, WR = 3'b001, RF = 3'b010;
	localparam logic [2:0] ML = 3'b000;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [17:0] coreData = 18'h00000;
	logic [17:0] readData;
	logic        readDataOe, readValidStrobe, refreshPulse, initDone;
	logic [1:0]  readDataClockPair;
	logic [19:0] coreAddr;
	logic [2:0]  coreBank, refreshBank;
	logic [12:0] refreshRow;
	pins_t       pins;
	int          ckRises;
	int          nErrors = 0;
	int          compares = 0;
	always #20 clk = ~clk;
	ll_ctrl_model m (.clk(clk), .pins(pins), .ckRises(ckRises));
	ll_dram_core DUT (.clk(clk), .rst(rst), .pins(pins),
		.coreData(coreData), .readData(readData), .readDataOe(readDataOe),
		.readDataClockPair(readDataClockPair),
		.readValidStrobe(readValidStrobe), .coreAddr(coreAddr),
		.coreBank(coreBank), .refreshPulse(refreshPulse),
		.refreshBank(refreshBank), .refreshRow(refreshRow),
		.initDone(initDone));
	function automatic logic [17:0] word(input logic [19:0] a);
		return a[17:0] ^ 18'h25A5A;
	endfunction : word
	always @(posedge clk) coreData <= word(coreAddr);
	task automatic check(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic conclude;
		$display("%0d compares, %0d mismatches", compares, nErrors);
		if (nErrors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	task automatic waitOn(ref logic s, input logic v, output int n);
		n = 0;
		while (s !== v && n < 400) begin
			@(posedge clk);
			#1 n++;
		end
	endtask : waitOn
	// Reads a, or a and a2 back to back with two writes right behind them.
	task automatic readBurst(input logic [19:0] a, a2, input bit two,
			input int rl, bl);
		int n0, n, i, tot;
		tot = two ? 2 * bl : bl;
		m.cmd(RD, 3'h1, a);
		n0 = ckRises + 1;
		if (two) begin
			m.cmd(RD, 3'h2, a2);
			m.cmd(WR, 3'h3, a2);
			m.cmd(WR, 3'h4, a2);
		end
		waitOn(readValidStrobe, 1'b1, n);
		check(readDataOe, 0);
		waitOn(readDataOe, 1'b1, n);
		check(n, 4);
		check(ckRises - n0, rl);
		for (i = 0; i < tot; i++) begin
			check(readData, word(i < bl ? a + i : a2 + i - bl));
			check(readValidStrobe, i < tot - 1);
			check(readDataOe, 1);
			repeat (4) @(posedge clk);
			#1;
		end
		check(readDataOe, 0);
		check(readData, 0);
		check(coreBank, two ? 3'h2 : 3'h1);
	endtask : readBurst
	task automatic refreshOne(input int b, input int row);
		int n;
		m.cmd(RF, b[2:0], 20'hFFFFF);
		waitOn(refreshPulse, 1'b1, n);
		check(n < 8, 1);
		check(refreshBank, b);
		check(refreshRow, row);
	endtask : refreshOne
	task automatic modeLoads;
		repeat (3) m.cmd(ML, 3'h0, 20'h00000);
	endtask : modeLoads
	task automatic tInit;
		int b;
		repeat (5000) @(posedge clk);
		modeLoads();
		for (b = 0; b < 8; b++)
			refreshOne(b, 0);
		repeat (8) @(posedge clk);
		check(initDone, 1);
		refreshOne(5, 1);
		modeLoads();
		// The third load is only taken a few clocks after the task returns.
		repeat (8) @(posedge clk);
		check(initDone, 0);
		refreshOne(5, 0);
		$display("init and refresh test done");
	endtask : tInit
	task automatic tModes;
		int c, s;
		for (c = 0; c < 3; c++) begin
			for (s = 0; s < 3; s++) begin
				m.cmd(ML, 3'h0, 20'(s * 8 + c));
				readBurst(20'(c * 64 + s * 16), 20'h0, 0, 4 + 2 * c, 2 << s);
			end
		end
		m.cmd(ML, 3'h0, 20'h00000);
		readBurst(20'h00200, 20'h00300, 1, 4, 2);
		$display("read mode test done");
	endtask : tModes
	task automatic tFault;
		int n;
		m.cmd(ML, 3'h0, 20'h00008);
		m.cmd(RD, 3'h1, 20'h00040);
		waitOn(readDataOe, 1'b1, n);
		@(posedge clk);
		m.diffOk <= 1'b0;
		repeat (4) @(posedge clk);
		m.diffOk <= 1'b1;
		waitOn(readDataOe, 1'b0, n);
		repeat (8) @(posedge clk);
		check(readValidStrobe, 1);
		m.cmd(RD, 3'h2, 20'h00080);
		waitOn(readDataOe, 1'b1, n);
		waitOn(readDataOe, 1'b0, n);
		check(readValidStrobe, 0);
		$display("clock fault test done");
	endtask : tFault
	task automatic tClocks;
		int t;
		logic p;
		t = 0;
		p = readDataClockPair[0];
		repeat (32) begin
			@(posedge clk);
			#1 t += int'(readDataClockPair[0] != p);
			p = readDataClockPair[0];
			check(readDataClockPair[1], p);
		end
		check(t, 8);
		$display("read clock test done");
	endtask : tClocks
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		tInit();
		tModes();
		tFault();
		tClocks();
		conclude();
	end
	// About four times the expected run, so a hang ends cleanly.
	initial begin
		#1000000;
		nErrors++;
		conclude();
	end
endmodule : ll_dram_core_tb
`default_nettype wire
